// File: design/pccr_consts.svh
/*
  Offsets, field positions, reset values and timing figures of the
  protocol clock capture register block.
  Assumes registers are decoded from paddr[11:0], one 32-bit word each.
*/
`ifndef PCCR_CONSTS_SVH
`define PCCR_CONSTS_SVH

// Per-port transmit source identifier, low word
`define PCCR_OFS_TXID_P1   12'h11c
`define PCCR_OFS_TXID_P2   12'h13c
`define PCCR_OFS_TXID_P0   12'h15c

// Pin timestamp capture pairs
`define PCCR_OFS_PINA_UP   12'h160
`define PCCR_OFS_PINA_LO   12'h164
`define PCCR_OFS_PINB_UP   12'h168
`define PCCR_OFS_PINB_LO   12'h16c

// Protocol clock and its rate tuning
`define PCCR_OFS_TIME_UP   12'h170
`define PCCR_OFS_TIME_LO   12'h174
`define PCCR_OFS_ADDEND    12'h178

// Control, command and status words
`define PCCR_OFS_CONFIG    12'h1a0
`define PCCR_OFS_COMMAND   12'h1a4
`define PCCR_OFS_STATUS    12'h1a8

// Field positions
`define PCCR_CFG_MASTER_LSB 0
`define PCCR_CFG_POL_A_BIT  8
`define PCCR_CFG_POL_B_BIT  9
`define PCCR_CMD_FREEZE_BIT 0
`define PCCR_STS_UP_BIT     0
`define PCCR_STS_LO_BIT     1

// Reset values
`define PCCR_RST_WORD      32'h0000_0000
`define PCCR_RST_TIME      64'h0000_0000_0000_0000
`define PCCR_RST_CONFIG    32'h0000_0000

// Timing: protocol clock rate against the bus clock rate
`define PCCR_PTP_RATE_MHZ  100
`define PCCR_PCLK_MHZ      100
`define PCCR_NOMINAL_STEP  (`PCCR_PTP_RATE_MHZ / `PCCR_PCLK_MHZ)

`endif

// File: design/pccr_pkg.sv
/*
  Types shared by the protocol clock capture register block.
  Assumes the constants header is compiled alongside.
*/
package pccr_pkg;

  // One packet detector report, valid for one cycle when seen is high
  typedef struct packed {
    logic        seen;
    logic        is_sync;
    logic        to_fabric;
    logic [31:0] src_id_lo;
  } pccr_detect_type;

  // One coherent 64-bit timestamp
  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
  } pccr_stamp_type;

  // Decoded register select
  typedef enum logic [3:0] {
    PCCR_SEL_NONE,
    PCCR_SEL_TXID_P1,
    PCCR_SEL_TXID_P2,
    PCCR_SEL_TXID_P0,
    PCCR_SEL_PINA_UP,
    PCCR_SEL_PINA_LO,
    PCCR_SEL_PINB_UP,
    PCCR_SEL_PINB_LO,
    PCCR_SEL_TIME_UP,
    PCCR_SEL_TIME_LO,
    PCCR_SEL_ADDEND,
    PCCR_SEL_CONFIG,
    PCCR_SEL_COMMAND,
    PCCR_SEL_STATUS
  } pccr_sel_type;

endpackage

// File: design/pccr_top.sv
/*
  Protocol clock, pin timestamp captures and per-port transmit source
  identifier captures, with an APB register slave.
  Assumes packet detectors run on pclk and report one-cycle events;
  timestamp pins are asynchronous and are synchronised here.
*/
// Added by the designer: register access over APB.
// Behaviour
// - Transmit capture loads source id low word
// - One source id register per port
// - Master bit picks sync or delay-request
// - Host port: into fabric counts as transmit
// - Pin A activation captures full clock
// - Pin B activation captures full clock
// - One clock value feeds both pin captures and the snapshot
// - Clock advances at nominal rate, tunable
// - Clock seen as two read/write words
// - Clock changes only after both words written
// - Clock reads return frozen snapshot copy
// - Addend accumulates each cycle, overflow paces
`timescale 1ns/1ps
`include "pccr_consts.svh"

module pccr_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire pccr_pkg::pccr_detect_type det_port0,
  input  wire pccr_pkg::pccr_detect_type det_port1,
  input  wire pccr_pkg::pccr_detect_type det_port2,
  input  wire logic                     pin_a,
  input  wire logic                     pin_b,
  output logic      [63:0]              ptp_time
);
  import pccr_pkg::*;

  localparam logic [63:0] NOMINAL_STEP = 64'(`PCCR_NOMINAL_STEP);

  // Address decode shared by the read and the write paths
  function automatic pccr_sel_type pccr_decode(input logic [11:0] a);
    pccr_sel_type s;
    s = PCCR_SEL_NONE;
    case (a)
      `PCCR_OFS_TXID_P1: s = PCCR_SEL_TXID_P1;
      `PCCR_OFS_TXID_P2: s = PCCR_SEL_TXID_P2;
      `PCCR_OFS_TXID_P0: s = PCCR_SEL_TXID_P0;
      `PCCR_OFS_PINA_UP: s = PCCR_SEL_PINA_UP;
      `PCCR_OFS_PINA_LO: s = PCCR_SEL_PINA_LO;
      `PCCR_OFS_PINB_UP: s = PCCR_SEL_PINB_UP;
      `PCCR_OFS_PINB_LO: s = PCCR_SEL_PINB_LO;
      `PCCR_OFS_TIME_UP: s = PCCR_SEL_TIME_UP;
      `PCCR_OFS_TIME_LO: s = PCCR_SEL_TIME_LO;
      `PCCR_OFS_ADDEND:  s = PCCR_SEL_ADDEND;
      `PCCR_OFS_CONFIG:  s = PCCR_SEL_CONFIG;
      `PCCR_OFS_COMMAND: s = PCCR_SEL_COMMAND;
      `PCCR_OFS_STATUS:  s = PCCR_SEL_STATUS;
      default:           s = PCCR_SEL_NONE;
    endcase
    return s;
  endfunction

  // Transmit capture qualifier for one port
  function automatic logic pccr_tx_hit(
    input pccr_detect_type d,
    input logic            master,
    input logic            host_port
  );
    logic is_tx;
    is_tx = host_port ? d.to_fabric : !d.to_fabric;
    return d.seen && is_tx && (d.is_sync == master);
  endfunction

  // Bus side state
  logic [31:0]    prdata_q;
  logic           pready_q;
  logic           pslverr_q;

  // Software registers
  logic [31:0]    addend_q;
  logic [31:0]    config_q;
  logic [31:0]    hold_upper_q;
  logic [31:0]    hold_lower_q;
  logic           pend_upper_q;
  logic           pend_lower_q;
  pccr_stamp_type snap_q;

  // Protocol clock and accumulator
  logic [63:0]    time_q;
  logic [63:0]    time_d;
  logic [31:0]    acc_q;

  // Captures
  logic [31:0]    txid_q [0:2];
  pccr_stamp_type pin_stamp_q [0:1];

  // Pin synchronisers and filtered levels
  logic [1:0]     sync1_q;
  logic [1:0]     sync2_q;
  logic [1:0]     sync3_q;
  logic [1:0]     level_q;

  // Bus phase decode
  wire            setup_phase = psel && !penable;
  wire            access_done = psel && penable && pready_q;
  wire            wr_done     = access_done && pwrite;
  pccr_sel_type   sel;
  assign sel = pccr_decode(paddr);

  wire            wr_time_up = wr_done && (sel == PCCR_SEL_TIME_UP);
  wire            wr_time_lo = wr_done && (sel == PCCR_SEL_TIME_LO);
  wire            wr_addend  = wr_done && (sel == PCCR_SEL_ADDEND);
  wire            wr_config  = wr_done && (sel == PCCR_SEL_CONFIG);
  wire            wr_command = wr_done && (sel == PCCR_SEL_COMMAND);
  wire            freeze     = wr_command &&
                               pwdata[`PCCR_CMD_FREEZE_BIT];

  // Clock load happens when the second word of a pair arrives
  wire            pair_done  = (wr_time_up && pend_lower_q) ||
                               (wr_time_lo && pend_upper_q);
  wire [31:0]     load_upper = wr_time_up ? pwdata : hold_upper_q;
  wire [31:0]     load_lower = wr_time_lo ? pwdata : hold_lower_q;

  // Accumulator overflow adds one extra tick to the nominal step
  wire [32:0]     acc_sum  = {1'b0, acc_q} + {1'b0, addend_q};
  wire            acc_carry = acc_sum[32];
  wire [63:0]     step     = NOMINAL_STEP + {63'h0, acc_carry};

  assign time_d = pair_done ? {load_upper, load_lower}
                            : time_q + step;

  // Per-port transmit capture strobes, port 0 is the host port
  wire [2:0]      tx_hit;
  assign tx_hit[0] = pccr_tx_hit(det_port0,
                                 config_q[`PCCR_CFG_MASTER_LSB],
                                 1'b1);
  assign tx_hit[1] = pccr_tx_hit(det_port1,
                                 config_q[`PCCR_CFG_MASTER_LSB + 1],
                                 1'b0);
  assign tx_hit[2] = pccr_tx_hit(det_port2,
                                 config_q[`PCCR_CFG_MASTER_LSB + 2],
                                 1'b0);
  wire [31:0]     det_id [0:2];
  assign det_id[0] = det_port0.src_id_lo;
  assign det_id[1] = det_port1.src_id_lo;
  assign det_id[2] = det_port2.src_id_lo;

  // Pin level accepted once the second and third stages agree
  wire [1:0]      agree   = ~(sync2_q ^ sync3_q);
  wire [1:0]      level_d = (agree & sync2_q) | (~agree & level_q);
  wire [1:0]      pin_pol = {config_q[`PCCR_CFG_POL_B_BIT],
                             config_q[`PCCR_CFG_POL_A_BIT]};
  wire [1:0]      rise    = ~level_q & level_d;
  wire [1:0]      fall    = level_q & ~level_d;
  // Polarity bit set selects the falling edge as activation
  wire [1:0]      pin_act = (~pin_pol & rise) | (pin_pol & fall);

  // Status word
  wire [31:0]     status_word = {30'h0, pend_lower_q, pend_upper_q};

  // Read selection
  wire [31:0]     rd_word =
    (sel == PCCR_SEL_TXID_P1) ? txid_q[1] :
    (sel == PCCR_SEL_TXID_P2) ? txid_q[2] :
    (sel == PCCR_SEL_TXID_P0) ? txid_q[0] :
    (sel == PCCR_SEL_PINA_UP) ? pin_stamp_q[0].upper :
    (sel == PCCR_SEL_PINA_LO) ? pin_stamp_q[0].lower :
    (sel == PCCR_SEL_PINB_UP) ? pin_stamp_q[1].upper :
    (sel == PCCR_SEL_PINB_LO) ? pin_stamp_q[1].lower :
    (sel == PCCR_SEL_TIME_UP) ? snap_q.upper :
    (sel == PCCR_SEL_TIME_LO) ? snap_q.lower :
    (sel == PCCR_SEL_ADDEND)  ? addend_q :
    (sel == PCCR_SEL_CONFIG)  ? config_q :
    (sel == PCCR_SEL_STATUS)  ? status_word :
                                `PCCR_RST_WORD;

  wire            rd_setup = setup_phase && !pwrite;
  wire            unmapped = (sel == PCCR_SEL_NONE);

  // Bus answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `PCCR_RST_WORD;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase && unmapped;
      prdata_q  <= rd_setup ? rd_word : `PCCR_RST_WORD;
    end
  end

  // Addend and configuration words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addend_q <= `PCCR_RST_WORD;
      config_q <= `PCCR_RST_CONFIG;
    end else begin
      if (wr_addend) begin
        addend_q <= pwdata;
      end
      if (wr_config) begin
        config_q <= pwdata & 32'h0000_0307;
      end
    end
  end

  // Half-written clock words wait here for their partner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_upper_q <= `PCCR_RST_WORD;
      hold_lower_q <= `PCCR_RST_WORD;
      pend_upper_q <= 1'b0;
      pend_lower_q <= 1'b0;
    end else begin
      if (wr_time_up) begin
        hold_upper_q <= pwdata;
      end
      if (wr_time_lo) begin
        hold_lower_q <= pwdata;
      end
      pend_upper_q <= !pair_done && (pend_upper_q || wr_time_up);
      pend_lower_q <= !pair_done && (pend_lower_q || wr_time_lo);
    end
  end

  // Protocol clock, accumulator and snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_q <= `PCCR_RST_TIME;
      acc_q  <= `PCCR_RST_WORD;
      snap_q <= `PCCR_RST_TIME;
    end else begin
      time_q <= time_d;
      acc_q  <= acc_sum[31:0];
      if (freeze) begin
        snap_q <= time_q;
      end
    end
  end

  // Transmit source identifier captures, one word per port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        txid_q[i] <= `PCCR_RST_WORD;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (tx_hit[i]) begin
          txid_q[i] <= det_id[i];
        end
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      sync3_q <= 2'h0;
      level_q <= 2'h0;
    end else begin
      sync1_q <= {pin_b, pin_a};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  // Pin timestamp pairs, both halves from one sample of the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_stamp_q[0] <= `PCCR_RST_TIME;
      pin_stamp_q[1] <= `PCCR_RST_TIME;
    end else begin
      if (pin_act[0]) begin
        pin_stamp_q[0] <= time_q;
      end
      if (pin_act[1]) begin
        pin_stamp_q[1] <= time_q;
      end
    end
  end

  // Outputs straight from flip-flops
  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign ptp_time = time_q;

endmodule

// File: bench/pccr_partner.sv
/*
  Packet detector and timestamp pin model at the far side of pccr_top.
  Assumes the testbench calls its tasks; pclk runs throughout.
*/
`timescale 1ns/1ps
module pccr_partner (
  input  wire logic                pclk,
  output pccr_pkg::pccr_detect_type det_port0,
  output pccr_pkg::pccr_detect_type det_port1,
  output pccr_pkg::pccr_detect_type det_port2,
  output logic                     pin_a,
  output logic                     pin_b
);
  import pccr_pkg::*;
  pccr_detect_type dt [3] = '{default: '0};
  initial begin
    pin_a = 1'h0;
    pin_b = 1'h0;
  end
  assign det_port0 = dt[0];
  assign det_port1 = dt[1];
  assign det_port2 = dt[2];
  task send(input int p, input logic s, input logic f, input logic [31:0] id);
    @(posedge pclk);
    dt[p] <= {1'h1, s, f, id};
    @(posedge pclk);
    // Stale fields scrambled once seen drops
    dt[p] <= {1'h0, ~s, ~f, ~id};
  endtask
  task pin(input logic b, input logic v);
    @(posedge pclk);
    if (b) begin
      pin_b <= v;
    end else begin
      pin_a <= v;
    end
  endtask
endmodule

// File: bench/pccr_chk.sv
/*
  Port-level assertions for pccr_top.
  Assumes aligned APB addresses; bound to every pccr_top instance.
*/
`timescale 1ns/1ps
module pccr_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [63:0] ptp_time
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {12'h11c, 12'h13c, 12'h15c, 12'h160,
    12'h164, 12'h168, 12'h16c, 12'h170, 12'h174, 12'h178, 12'h1a0,
    12'h1a4, 12'h1a8};
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  setup_ans_a: assert property (setup_s |=> answer_s)
    else $error("setup not answered in one cycle");
  idle_ready_a: assert property (!psel |=> !pready)
    else $error("ready without select");
  ready_hold_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  rdata_zero_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  unmapped_err_a: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access flagged");
  time_step_a: assert property ($past(presetn) &&
    !$past(psel && penable && pwrite && paddr[11:4] == 8'h17) |->
    (ptp_time - $past(ptp_time)) inside {64'h1, 64'h2})
    else $error("clock step not one or two");
endmodule
bind pccr_top pccr_chk pccr_chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .ptp_time);

// File: bench/testbench.sv
/*
  Self-checking bench for pccr_top: APB master, table of register cases,
  detector, pin, pair-load, snapshot and addend tests.
  Assumes pccr_partner drives the detector and pin inputs.
*/
`timescale 1ns/1ps
module testbench;
  import pccr_pkg::*;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic        e;
  } pccr_row_type;
  logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]     paddr = 12'h0;
  logic [31:0]     pwdata = 32'h0, prdata, rd, rd2;
  logic            pready, pslverr, pin_a, pin_b, er;
  logic [63:0]     ptp_time, base;
  pccr_detect_type det_port0, det_port1, det_port2;
  int              cyc = 0, k0, k1, kp, bad_count = 0, tests_run = 0;
  pccr_row_type    rows [13] = '{
    {1'h0, 12'h11c, 32'h0, 1'h0}, {1'h0, 12'h13c, 32'h0, 1'h0},
    {1'h0, 12'h15c, 32'h0, 1'h0}, {1'h0, 12'h160, 32'h0, 1'h0},
    {1'h0, 12'h164, 32'h0, 1'h0}, {1'h0, 12'h168, 32'h0, 1'h0},
    {1'h0, 12'h16c, 32'h0, 1'h0}, {1'h0, 12'h170, 32'h0, 1'h0},
    {1'h0, 12'h174, 32'h0, 1'h0}, {1'h1, 12'h11c, 32'hffffffff, 1'h0},
    {1'h0, 12'h11c, 32'h0, 1'h0}, {1'h0, 12'h100, 32'h0, 1'h1},
    {1'h1, 12'h1fc, 32'h5, 1'h1}};
  pccr_top pccr_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .det_port0, .det_port1,
    .det_port2, .pin_a, .pin_b, .ptp_time);
  pccr_partner pccr_partner_i (.pclk, .det_port0, .det_port1, .det_port2,
    .pin_a, .pin_b);
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  task cmp(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task cmp_in(input logic [63:0] g, input logic [63:0] lo, input int span);
    tests_run++;
    if ((g >= lo && g <= lo + 64'(span)) !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %h not near %h", $time, g, lo);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    k0 = cyc;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    cmp(ptp_time, 64'h0);
    cmp(pready, 64'h0);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      cmp(er, rows[i].e);
      cmp(rd, 64'h0);
    end
    // Ports 0 and 2 master, port 1 slave, pin B falling edge
    apb(1'h1, 12'h1a0, 32'h0000_0205);
    pccr_partner_i.send(1, 1'h0, 1'h0, 32'ha1a1_0001);
    pccr_partner_i.send(1, 1'h1, 1'h0, 32'hbad0_0001);
    pccr_partner_i.send(1, 1'h0, 1'h1, 32'hbad0_0002);
    pccr_partner_i.send(2, 1'h1, 1'h0, 32'ha2a2_0002);
    pccr_partner_i.send(0, 1'h1, 1'h1, 32'ha0a0_0000);
    pccr_partner_i.send(0, 1'h1, 1'h0, 32'hbad0_0003);
    apb(1'h0, 12'h11c, 32'h0);
    cmp(rd, 64'ha1a1_0001);
    apb(1'h0, 12'h13c, 32'h0);
    cmp(rd, 64'ha2a2_0002);
    apb(1'h0, 12'h15c, 32'h0);
    cmp(rd, 64'ha0a0_0000);
    apb(1'h1, 12'h170, 32'h0000_0012);
    apb(1'h0, 12'h1a8, 32'h0);
    cmp(rd, 64'h1);
    cmp(ptp_time[63:32], 64'h0);
    apb(1'h1, 12'h174, 32'hffff_fff8);
    #1 cmp(ptp_time, 64'h12_ffff_fff8);
    base = 64'h12_ffff_fff8;
    k1 = k0;
    // Pin A capture lands just before the lower word wrap; the check window spans it
    pccr_partner_i.pin(1'h0, 1'h1);
    kp = cyc;
    repeat (6) @(posedge pclk);
    apb(1'h0, 12'h160, 32'h0);
    rd2 = rd;
    apb(1'h0, 12'h164, 32'h0);
    cmp_in({rd2, rd}, base + 64'(kp - k1), 8);
    pccr_partner_i.pin(1'h1, 1'h1);
    repeat (6) @(posedge pclk);
    apb(1'h0, 12'h168, 32'h0);
    cmp(rd, 64'h0);
    pccr_partner_i.pin(1'h1, 1'h0);
    kp = cyc;
    repeat (6) @(posedge pclk);
    apb(1'h0, 12'h168, 32'h0);
    rd2 = rd;
    apb(1'h0, 12'h16c, 32'h0);
    cmp_in({rd2, rd}, base + 64'(kp - k1), 8);
    apb(1'h1, 12'h1a4, 32'h1);
    kp = k0;
    apb(1'h0, 12'h170, 32'h0);
    rd2 = rd;
    repeat (20) @(posedge pclk);
    apb(1'h0, 12'h174, 32'h0);
    cmp({rd2, rd}, base + 64'(kp - k1 - 1));
    // Half-rate addend: five extra ticks in ten cycles
    apb(1'h1, 12'h178, 32'h8000_0000);
    #1 base = ptp_time;
    repeat (10) @(posedge pclk);
    #1 cmp(ptp_time - base, 64'hf);
    apb(1'h0, 12'h178, 32'h0);
    cmp(rd, 64'h8000_0000);
    apb(1'h0, 12'h1a0, 32'h0);
    cmp(rd, 64'h205);
    presetn <= 1'h0;
    @(posedge pclk);
    #1 cmp(ptp_time, 64'h0);
    presetn <= 1'h1;
    apb(1'h0, 12'h11c, 32'h0);
    cmp(rd, 64'h0);
    tally_and_finish;
  end
endmodule
